// *** verilog/tlpg_top.sv ***
// What this block does
// - Free-run bit 0 keeps the low-power behaviour on whatever keys do.
// - Free-run bit 1 suspends low power while any key detects.
// - Factor is bits 5..0 of the low-power byte; bit 7 is zero.
// - Factor 0x00 or 0x1a..0x3e disables low power.
// - Factor 0x01..0x19 sleeps for factor times 20 ms.
// - Factor 0x3f enters deep sleep, left only on reset or bus traffic.
// - Any bus activity wakes the device from sleep or deep sleep.
// - An address that wakes the device is not acknowledged.
// - Output byte bits 4..0 drive output pins five to one.
// - Group mode bit 0 selects locking: first key blocks the rest.
// - Group mode bit 1 reports the strongest key of the group.
// - Key group byte bit x-1 makes the key a member of group x.
// - Per-key debug state uses the fixed code table.
`timescale 1ns/100ps
`default_nettype none
`include "tlpg_defs.svh"

module tlpg_top (
    input  wire logic                   i_mclk,
    input  wire logic                   i_arst_n,
    input  wire logic                   i_byte_valid,
    input  wire logic [7:0]             i_byte_data,
    input  wire logic                   i_frame_start,
    input  wire logic                   i_bus_activity,
    input  wire logic                   i_addr_match,
    input  wire logic [7:0]             i_key_detect,
    input  wire logic [63:0]            i_key_signal,
    input  wire logic [23:0]            i_key_state,
    input  wire logic [2:0]             i_dbg_key_sel,
    output logic                        o_addr_ack,
    output logic                        o_cmd_done,
    output logic                        o_cmd_bad,
    output logic                        o_low_power_active,
    output logic                        o_deep_sleep,
    output logic                        o_sleeping,
    output logic [4:0]                  o_aux_output_levels,
    output logic [7:0]                  o_suppression_group_mode,
    output logic [7:0]                  o_key_reported,
    output logic [7:0]                  o_key_debug_code
);
    import tlpg_pkg::*;

    // Pin synchronisers
    logic       act_s1_reg, act_s2_reg;
    logic [7:0] det_s1_reg, det_s2_reg;
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            act_s1_reg <= 1'b0;
            act_s2_reg <= 1'b0;
            det_s1_reg <= 8'h00;
            det_s2_reg <= 8'h00;
        end else begin
            act_s1_reg <= i_bus_activity;
            act_s2_reg <= act_s1_reg;
            det_s1_reg <= i_key_detect;
            det_s2_reg <= det_s1_reg;
        end
    end

    // Command decoder
    tlpg_state_t st_reg, st_next;
    logic [7:0]  csum_reg, csum_next;
    logic [7:0]  lp_reg, lp_next, lp_new_reg, lp_new_next;
    logic [4:0]  out_reg, out_next, out_new_reg, out_new_next;
    logic [7:0]  gmode_reg, gmode_next, gmode_new_reg, gmode_new_next;
    logic [7:0]  grp_reg [8];
    logic [7:0]  grp_new_reg [8];
    logic [3:0]  cnt_reg, cnt_next;
    logic [1:0]  kind_reg, kind_next;
    logic        done_next, bad_next, commit;

    always_comb begin
        st_next        = st_reg;
        csum_next      = csum_reg;
        lp_next        = lp_reg;
        lp_new_next    = lp_new_reg;
        out_next       = out_reg;
        out_new_next   = out_new_reg;
        gmode_next     = gmode_reg;
        gmode_new_next = gmode_new_reg;
        cnt_next       = cnt_reg;
        kind_next      = kind_reg;
        done_next      = 1'b0;
        bad_next       = 1'b0;
        commit         = 1'b0;
        if (i_frame_start) begin
            st_next = TLPG_IDLE;
        end else if (i_byte_valid) begin
            csum_next = csum_reg + i_byte_data;
            case (st_reg)
                TLPG_IDLE: begin
                    csum_next = i_byte_data;
                    if (i_byte_data == `TLPG_CMD_LOW_POWER) begin
                        st_next = TLPG_LP_ARG;
                    end else if (i_byte_data == `TLPG_CMD_GROUP_PRE0) begin
                        st_next = TLPG_PRE1;
                    end else if (i_byte_data == `TLPG_CMD_OUTPUTS) begin
                        st_next = TLPG_OUTARG;
                    end else begin
                        bad_next = 1'b1;
                    end
                end
                TLPG_LP_ARG: begin
                    lp_new_next = {1'b0, i_byte_data[6:0]};
                    kind_next   = 2'd0;
                    st_next     = TLPG_CSUM;
                end
                TLPG_PRE1: begin
                    if (i_byte_data == `TLPG_CMD_GROUP_PRE1) begin
                        st_next = TLPG_GMODE;
                    end else begin
                        st_next  = TLPG_IDLE;
                        bad_next = 1'b1;
                    end
                end
                TLPG_GMODE: begin
                    gmode_new_next = i_byte_data;
                    cnt_next       = 4'h0;
                    st_next        = TLPG_GKEYS;
                end
                TLPG_GKEYS: begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == `TLPG_GROUP_BYTES - 4'h1) begin
                        kind_next = 2'd1;
                        st_next   = TLPG_CSUM;
                    end
                end
                TLPG_OUTARG: begin
                    out_new_next = i_byte_data[`TLPG_OUT_MSB:0];
                    kind_next    = 2'd2;
                    st_next      = TLPG_CSUM;
                end
                TLPG_CSUM: begin
                    st_next = TLPG_IDLE;
                    // Commit only on a matching checksum
                    if (i_byte_data == csum_reg) begin
                        commit    = 1'b1;
                        done_next = 1'b1;
                        case (kind_reg)
                            2'd0:    lp_next    = lp_new_reg;
                            2'd1:    gmode_next = gmode_new_reg;
                            default: out_next   = out_new_reg;
                        endcase
                    end else begin
                        bad_next = 1'b1;
                    end
                end
                default: st_next = TLPG_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg        <= TLPG_IDLE;
            csum_reg      <= 8'h00;
            lp_reg        <= 8'h00;
            lp_new_reg    <= 8'h00;
            out_reg       <= 5'h00;
            out_new_reg   <= 5'h00;
            gmode_reg     <= 8'h00;
            gmode_new_reg <= 8'h00;
            cnt_reg       <= 4'h0;
            kind_reg      <= 2'd0;
            o_cmd_done    <= 1'b0;
            o_cmd_bad     <= 1'b0;
        end else begin
            st_reg        <= st_next;
            csum_reg      <= csum_next;
            lp_reg        <= lp_next;
            lp_new_reg    <= lp_new_next;
            out_reg       <= out_next;
            out_new_reg   <= out_new_next;
            gmode_reg     <= gmode_next;
            gmode_new_reg <= gmode_new_next;
            cnt_reg       <= cnt_next;
            kind_reg      <= kind_next;
            o_cmd_done    <= done_next;
            o_cmd_bad     <= bad_next;
        end
    end

    // Key membership bytes, staged then committed
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int k = 0; k < 8; k++) begin
                grp_reg[k]     <= 8'h00;
                grp_new_reg[k] <= 8'h00;
            end
        end else begin
            if (st_reg == TLPG_GKEYS && i_byte_valid && !i_frame_start)
                grp_new_reg[cnt_reg[2:0]] <= i_byte_data;
            if (commit && kind_reg == 2'd1)
                for (int k = 0; k < 8; k++)
                    grp_reg[k] <= grp_new_reg[k];
        end
    end

    assign o_aux_output_levels      = out_reg;
    assign o_suppression_group_mode = gmode_reg;

    // Power manager
    logic [5:0]  factor;
    logic        any_detect, lp_enabled, suspend, wake;
    tlpg_pwr_t   pwr_reg, pwr_next;
    logic [31:0] tick_reg, tick_next;
    logic [5:0]  units_reg, units_next;
    logic        ack_next;
    assign factor     = lp_reg[`TLPG_FACTOR_MSB:0];
    assign any_detect = |det_s2_reg;
    // Only 0x01..0x19 enables timed low power
    assign lp_enabled = factor != `TLPG_FACTOR_OFF &&
                        factor <= `TLPG_FACTOR_MAX;
    assign suspend    = lp_reg[`TLPG_FREE_RUN_BIT] && any_detect;
    assign wake       = act_s2_reg;

    always_comb begin
        pwr_next   = pwr_reg;
        tick_next  = tick_reg;
        units_next = units_reg;
        ack_next   = i_addr_match;
        case (pwr_reg)
            TLPG_PWR_RUN: begin
                // Deep sleep once factor is 0x3f, in a cycle with no commit and no bus activity
                if (factor == `TLPG_FACTOR_DEEP && commit == 1'b0 &&
                    !wake) begin
                    pwr_next = TLPG_PWR_DEEP;
                end else if (lp_enabled && !suspend && !wake) begin
                    pwr_next   = TLPG_PWR_SLEEP;
                    tick_next  = 32'd0;
                    units_next = 6'd0;
                end
            end
            TLPG_PWR_SLEEP: begin
                // Sleep period factor times 20 ms
                tick_next = tick_reg + 32'd1;
                if (tick_reg == 32'(`TLPG_CYC_PER_UNIT) - 32'd1) begin
                    tick_next  = 32'd0;
                    units_next = units_reg + 6'd1;
                end
                if (wake || suspend || !lp_enabled ||
                    units_reg == factor) begin
                    pwr_next = TLPG_PWR_RUN;
                end
                ack_next = 1'b0;
            end
            TLPG_PWR_DEEP: begin
                if (wake) pwr_next = TLPG_PWR_RUN;
                ack_next = 1'b0;
            end
            default: pwr_next = TLPG_PWR_RUN;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pwr_reg    <= TLPG_PWR_RUN;
            tick_reg   <= 32'd0;
            units_reg  <= 6'd0;
        end else begin
            pwr_reg    <= pwr_next;
            tick_reg   <= tick_next;
            units_reg  <= units_next;
        end
    end
    assign o_addr_ack         = ack_next;
    assign o_sleeping         = pwr_reg == TLPG_PWR_SLEEP;
    assign o_deep_sleep       = pwr_reg == TLPG_PWR_DEEP;
    assign o_low_power_active = lp_enabled && !suspend;

    // Suppression groups
    logic [7:0] rep_next, rep_reg;
    always_comb begin
        logic [7:0] blocked;
        logic [7:0] best;
        blocked  = 8'h00;
        best     = 8'h00;
        for (int g = 0; g < 8; g++) begin
            best = 8'h00;
            for (int k = 0; k < 8; k++) begin
                if (grp_reg[k][g] && det_s2_reg[k]) begin
                    if (gmode_reg[g]) begin
                        if (i_key_signal[k*8 +: 8] < best)
                            blocked[k] = 1'b1;
                        else
                            best = i_key_signal[k*8 +: 8];
                    end else if (rep_reg[k] == 1'b0) begin
                        // Held or lower new key locks out
                        for (int j = 0; j < 8; j++)
                            if (j != k && grp_reg[j][g] &&
                                (rep_reg[j] || (j < k && det_s2_reg[j])))
                                blocked[k] = 1'b1;
                    end
                end
            end
            if (gmode_reg[g]) begin
                for (int k = 0; k < 8; k++)
                    if (grp_reg[k][g] && det_s2_reg[k] &&
                        i_key_signal[k*8 +: 8] < best)
                        blocked[k] = 1'b1;
            end
        end
        rep_next = det_s2_reg & ~blocked;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rep_reg <= 8'h00;
        end else begin
            rep_reg <= rep_next;
        end
    end
    assign o_key_reported = rep_reg;

    logic [7:0] dbg_next;
    always_comb begin
        case (tlpg_key_state_t'(i_key_state[i_dbg_key_sel*3 +: 3]))
            TLPG_KS_CAL:      dbg_next = `TLPG_DBG_CAL;
            TLPG_KS_RELEASED: dbg_next = `TLPG_DBG_RELEASED;
            TLPG_KS_TOUCHED:  dbg_next = `TLPG_DBG_TOUCHED;
            TLPG_KS_ERROR:    dbg_next = `TLPG_DBG_ERROR;
            TLPG_KS_RECAL:    dbg_next = `TLPG_DBG_RECAL_FILT;
            TLPG_KS_DETECT:   dbg_next = `TLPG_DBG_DET_FILT;
            TLPG_KS_EOD:      dbg_next = `TLPG_DBG_EOD_FILT;
            default:          dbg_next = `TLPG_DBG_ERROR;
        endcase
    end
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_key_debug_code <= `TLPG_DBG_CAL;
        end else begin
            o_key_debug_code <= dbg_next;
        end
    end

    chk_sleep_no_ack: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        (pwr_reg != TLPG_PWR_RUN) |-> !o_addr_ack)
        else $error("address acknowledged while asleep");
    chk_deep_wakes: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        (o_deep_sleep && act_s2_reg) |=> !o_deep_sleep)
        else $error("deep sleep not left on bus activity");
    chk_bad_no_commit: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        o_cmd_bad |-> $stable(lp_reg))
        else $error("rejected command changed setting");
    chk_disabled_runs: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        (!lp_enabled && factor != `TLPG_FACTOR_DEEP) |=> !o_sleeping)
        else $error("sleeping with low power disabled");
    chk_free_run: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        (lp_reg[`TLPG_FREE_RUN_BIT] && any_detect) |-> !o_low_power_active)
        else $error("low power active during detect");
    chk_report_subset: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        (o_key_reported & ~$past(det_s2_reg)) == 8'h00)
        else $error("reported key not detecting");
    chk_out_levels: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        (o_cmd_done && kind_reg == 2'd2) |-> o_aux_output_levels == out_new_reg)
        else $error("output levels not applied");
    chk_debug_code: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        (i_key_state[i_dbg_key_sel*3 +: 3] == TLPG_KS_TOUCHED) |=>
            o_key_debug_code == `TLPG_DBG_TOUCHED)
        else $error("touched code wrong");
endmodule // tlpg_top
`default_nettype wire

// *** verilog/tlpg_defs.svh ***
`ifndef TLPG_DEFS_SVH
`define TLPG_DEFS_SVH

`define TLPG_CMD_LOW_POWER   8'h92
`define TLPG_CMD_GROUP_PRE0  8'h00
`define TLPG_CMD_GROUP_PRE1  8'h09
`define TLPG_CMD_OUTPUTS     8'h95
`define TLPG_FREE_RUN_BIT    6
`define TLPG_FACTOR_MSB      5
`define TLPG_FACTOR_DEEP     6'h3f
`define TLPG_FACTOR_MAX      6'h19
`define TLPG_FACTOR_OFF      6'h00
`define TLPG_OUT_MSB         4
`define TLPG_SLEEP_UNIT_MS   20
`define TLPG_CLK_MHZ         100
`define TLPG_CYC_PER_UNIT    (`TLPG_SLEEP_UNIT_MS * 1000 * `TLPG_CLK_MHZ)
`define TLPG_GROUP_BYTES     4'h8
`define TLPG_DBG_CAL         8'h01
`define TLPG_DBG_RELEASED    8'h02
`define TLPG_DBG_TOUCHED     8'h04
`define TLPG_DBG_ERROR       8'h08
`define TLPG_DBG_RECAL_FILT  8'h11
`define TLPG_DBG_DET_FILT    8'h14
`define TLPG_DBG_EOD_FILT    8'h24

`endif

// *** verilog/tlpg_pkg.sv ***
`default_nettype none
package tlpg_pkg;
    typedef enum logic [2:0] {
        TLPG_IDLE   = 3'b000,
        TLPG_LP_ARG = 3'b001,
        TLPG_PRE1   = 3'b010,
        TLPG_GMODE  = 3'b011,
        TLPG_GKEYS  = 3'b100,
        TLPG_OUTARG = 3'b101,
        TLPG_CSUM   = 3'b110
    } tlpg_state_t;

    typedef enum logic [1:0] {
        TLPG_PWR_RUN   = 2'b00,
        TLPG_PWR_SLEEP = 2'b01,
        TLPG_PWR_DEEP  = 2'b10
    } tlpg_pwr_t;

    typedef enum logic [2:0] {
        TLPG_KS_CAL      = 3'b000,
        TLPG_KS_RELEASED = 3'b001,
        TLPG_KS_TOUCHED  = 3'b010,
        TLPG_KS_ERROR    = 3'b011,
        TLPG_KS_RECAL    = 3'b100,
        TLPG_KS_DETECT   = 3'b101,
        TLPG_KS_EOD      = 3'b110
    } tlpg_key_state_t;
endpackage
`default_nettype wire

// *** sim/tlpg_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module tlpg_host_model (
    input  wire logic       i_mclk,
    input  wire logic       i_cmd_done,
    input  wire logic       i_cmd_bad,
    input  wire logic       i_addr_ack,
    output logic            o_byte_valid,
    output logic [7:0]      o_byte_data,
    output logic            o_frame_start,
    output logic            o_bus_activity,
    output logic            o_addr_match
);
    initial begin
        o_byte_valid = 1'b0;
        o_byte_data = 8'h5a;
        o_frame_start = 1'b0;
        o_bus_activity = 1'b0;
        o_addr_match = 1'b0;
    end

    task automatic bus(input logic act, input logic match);
        @(posedge i_mclk);
        o_bus_activity <= act;
        o_addr_match <= match;
    endtask

    task automatic send(input logic [7:0] b[$], input logic badcs,
                        output logic [1:0] resp);
        logic [7:0] sum;
        logic       acked;
        sum = 8'h00;
        foreach (b[i]) sum += b[i];
        b.push_back(sum + {7'h00, badcs});
        resp = 2'b00;
        for (int t = 0; t < 2 && resp == 2'b00; t++) begin
            bus(1'b1, 1'b1);
            @(posedge i_mclk);
            acked = i_addr_ack;
            o_addr_match <= 1'b0;
            repeat (3) @(posedge i_mclk);
            if (acked) begin
                o_frame_start <= 1'b1;
                for (int i = 0; i < b.size() + 6; i++) begin
                    @(posedge i_mclk);
                    resp |= {i_cmd_bad, i_cmd_done};
                    o_frame_start <= 1'b0;
                    o_byte_valid <= (i < b.size());
                    o_byte_data <= (i < b.size()) ? b[i] : ~b[b.size()-1];
                end
            end
        end
        o_bus_activity <= 1'b0;
    endtask
endmodule // tlpg_host_model
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        i_mclk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic [7:0]  i_key_detect = 8'h00;
    logic [63:0] i_key_signal = 64'h0;
    logic [23:0] i_key_state = 24'h0;
    logic [2:0]  i_dbg_key_sel = 3'h0;
    logic        bv, fs, ba, am, ack, done, bad, lpa, deep, slp;
    logic [7:0]  bd, gm, rep, dbg;
    logic [4:0]  aux;
    logic [1:0]  rs;
    int          fail_count = 0;
    int          num_checks = 0;
    int          seed = 32'h4556;
    logic [7:0]  dbg_tab [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h11,
                                 8'h14, 8'h24};

    tlpg_top i_tlpg_top (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .i_byte_valid(bv), .i_byte_data(bd), .i_frame_start(fs),
        .i_bus_activity(ba), .i_addr_match(am),
        .i_key_detect(i_key_detect), .i_key_signal(i_key_signal),
        .i_key_state(i_key_state), .i_dbg_key_sel(i_dbg_key_sel),
        .o_addr_ack(ack), .o_cmd_done(done), .o_cmd_bad(bad),
        .o_low_power_active(lpa), .o_deep_sleep(deep), .o_sleeping(slp),
        .o_aux_output_levels(aux), .o_suppression_group_mode(gm),
        .o_key_reported(rep), .o_key_debug_code(dbg));

    tlpg_host_model i_tlpg_host_model (.i_mclk(i_mclk),
        .i_cmd_done(done), .i_cmd_bad(bad), .i_addr_ack(ack),
        .o_byte_valid(bv),
        .o_byte_data(bd), .o_frame_start(fs), .o_bus_activity(ba),
        .o_addr_match(am));

    always #5 i_mclk = ~i_mclk;

    task automatic end_sim;
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic cmd(input logic [7:0] b[$], input logic badcs,
                       input logic eb);
        i_tlpg_host_model.send(b, badcs, rs);
        chk("response", {6'h00, eb, ~eb}, {6'h00, rs});
    endtask

    task automatic wt(input string nm, input int s, input logic v);
        logic c;
        for (int n = 0; n <= 40; n++) begin
            c = (s == 0) ? slp : deep;
            if (c === v) break;
            if (n == 40) begin
                chk(nm, {7'h00, v}, {7'h00, c});
                end_sim();
            end
            @(posedge i_mclk);
            #1;
        end
    endtask

    function automatic logic lp_exp(input logic [7:0] s,
                                    input logic [7:0] d);
        return s[5:0] >= 6'h01 && s[5:0] <= 6'h19 && !(s[6] && d != 0);
    endfunction

    function automatic logic [7:0] strongest(input logic [7:0] m,
                                             input logic [63:0] sg);
        int b = -1;
        int v = -1;
        for (int k = 0; k < 8; k++) begin
            if (m[k] && int'(sg[8*k +: 8]) > v) begin
                v = int'(sg[8*k +: 8]);
                b = k;
            end
        end
        return (b < 0) ? 8'h00 : 8'h01 << b;
    endfunction

    initial begin
        repeat (100000) @(posedge i_mclk);
        fail_count++;
        end_sim();
    end

    initial begin
        logic [7:0]  lv, q[$], fl[$];
        logic [23:0] st;
        logic [63:0] sg;
        repeat (6) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        chk("aux", 8'h00, {3'h0, aux});
        chk("group_mode", 8'h00, gm);
        chk("power", 8'h00, {5'h00, deep, slp, lpa});
        chk("debug_code", 8'h01, dbg);
        for (int i = 0; i < 7; i++) begin
            lv = 8'($random(seed)) & 8'h07;
            st = 24'($random(seed));
            st[3*lv +: 3] = i[2:0];
            @(posedge i_mclk);
            i_dbg_key_sel <= lv[2:0];
            i_key_state <= st;
            repeat (3) @(posedge i_mclk);
            #1 chk("debug_code", dbg_tab[i], dbg);
        end
        for (int i = 0; i < 3; i++) begin
            lv = 8'($random(seed)) & 8'h1f;
            cmd('{8'h95, lv}, 1'b0, 1'b0);
            chk("aux", lv, {3'h0, aux});
        end
        cmd('{8'h95, ~lv & 8'h1f}, 1'b1, 1'b1);
        chk("aux", lv, {3'h0, aux});
        cmd('{8'hc3}, 1'b0, 1'b1);
        cmd('{8'h00, 8'h07}, 1'b0, 1'b1);
        lv = 8'($random(seed));
        q = '{8'h00, 8'h09, lv};
        for (int i = 0; i < 8; i++) q.push_back(8'($random(seed)));
        cmd(q, 1'b0, 1'b0);
        chk("group_mode", lv, gm);
        sg = {$random(seed), $random(seed)};
        sg[15:0] = 16'hf010;
        i_key_signal <= sg;
        cmd('{8'h00, 8'h09, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h00}, 1'b0, 1'b0);
        i_key_detect <= 8'h01;
        repeat (6) @(posedge i_mclk);
        #1 chk("reported", 8'h01, rep);
        i_key_detect <= 8'h03;
        repeat (6) @(posedge i_mclk);
        #1 chk("reported", 8'h01, rep);
        i_key_detect <= 8'h00;
        repeat (6) @(posedge i_mclk);
        i_key_detect <= 8'h03;
        repeat (6) @(posedge i_mclk);
        #1 chk("reported", 8'h01, rep);
        i_key_detect <= 8'h00;
        cmd('{8'h00, 8'h09, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h00}, 1'b0, 1'b0);
        i_key_detect <= 8'h03;
        repeat (6) @(posedge i_mclk);
        #1 chk("reported", strongest(8'h03, sg), rep);
        sg[15:0] = 16'h20c0;
        i_key_signal <= sg;
        repeat (6) @(posedge i_mclk);
        #1 chk("reported", strongest(8'h03, sg), rep);
        i_key_detect <= 8'h00;
        fl = '{8'h00, 8'h1a, 8'h3e, 8'h19, 8'h01};
        foreach (fl[j]) begin
            cmd('{8'h92, fl[j]}, 1'b0, 1'b0);
            chk("lp_active", {7'h00, lp_exp(fl[j], 0)}, {7'h00, lpa});
        end
        wt("sleeping", 0, 1'b1);
        chk("sleeping", 8'h01, {7'h00, slp});
        i_tlpg_host_model.bus(1'b1, 1'b1);
        #1 chk("addr_ack", 8'h00, {7'h00, ack});
        wt("sleeping", 0, 1'b0);
        chk("addr_ack", 8'h01, {7'h00, ack});
        i_tlpg_host_model.bus(1'b0, 1'b0);
        for (int j = 0; j < 2; j++) begin
            lv = j ? 8'h45 : 8'h05;
            cmd('{8'h92, lv}, 1'b0, 1'b0);
            i_key_detect <= 8'h04;
            repeat (6) @(posedge i_mclk);
            #1 chk("lp_active", {7'h00, lp_exp(lv, 8'h04)}, {7'h00, lpa});
            i_key_detect <= 8'h00;
            repeat (6) @(posedge i_mclk);
            #1 chk("lp_active", {7'h00, lp_exp(lv, 0)}, {7'h00, lpa});
        end
        cmd('{8'h92, 8'h3f}, 1'b0, 1'b0);
        wt("deep", 1, 1'b1);
        chk("deep", 8'h01, {7'h00, deep});
        i_tlpg_host_model.bus(1'b1, 1'b0);
        wt("deep", 1, 1'b0);
        chk("deep", 8'h00, {7'h00, deep});
        i_tlpg_host_model.bus(1'b0, 1'b0);
        cmd('{8'h92, 8'h00}, 1'b0, 1'b0);
        repeat (6) @(posedge i_mclk);
        #1 chk("power", 8'h00, {5'h00, deep, slp, lpa});
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
